// [rtl/dma_channel_control.sv]
// per-channel control, status, chaining and arbitration of a dma engine
// Contract
// - A channel reads busy while it is switched on or still moving data.
// - Chain direction one follows the next higher-numbered channel, zero the next lower-numbered.
// - The chain direction matters only when chaining is allowed.
// - Writing the on bit one switches the channel on and zero switches it off.
// - Start and abort events while off are kept only if allowed, else dropped.
// - A neighbour's completion can switch a channel on only with chain-allow set.
// - Without auto re-enable the channel switches itself off at block end.
// - The event-detected bit reads one after an event and zero while none is seen.
// - The two-bit level is the channel priority, three highest and zero lowest.
// - Switching off waits for the running transaction; software polls busy.
// - Bits 31 to 16, 14 to 9 and 3 of the control word read as zero.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module dma_channel_control #(
   parameter int N  = 4,
   parameter int CW = (N > 1) ? $clog2(N) : 1
) (
   // clock, reset, enable
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          ce,
   // register port
   input  wire logic [7:0]    busAddr,
   input  wire logic [31:0]   busWdata,
   input  wire logic          busWrite,
   input  wire logic          busRead,
   output logic [31:0]        busRdata,
   // channel events from trigger logic on this clock
   input  wire logic [N-1:0]  startEvent,
   input  wire logic [N-1:0]  abortEvent,
   // data mover
   output logic               moveStart,
   output logic [CW-1:0]      moveChannel,
   input  wire logic          moveDone,
   input  wire logic          moveBlockEnd,
   // interrupt
   output logic               irq
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   dma_channel_pkg::ctrl_t   ctrl [N];
   logic [N-1:0]             pending;
   logic [N-1:0]             eventDetected;
   logic [N-1:0]             doneStat;
   logic [N-1:0]             abortStat;
   logic [31:0]              irqMask;
   logic                     active;
   logic [CW-1:0]            activeCh;

   // ------------------------------------------------------------------
   // decode and per-channel wires
   // ------------------------------------------------------------------
   dma_channel_pkg::bus_req_t req;
   logic [N-1:0]             ctrlSel;
   logic [N-1:0]             accept;
   logic [N-1:0]             startOk;
   logic [N-1:0]             abortOk;
   logic [N-1:0]             blockEnd;
   logic [N-1:0]             request;
   logic [N-1:0]             busy;
   logic [N-1:0]             chainHit;
   logic [N-1:0]             granted;
   logic [2*N-1:0]           prioFlat;
   logic [31:0]              ctrlWord [N];
   logic [31:0]              statusWord;
   logic                     statusSel;
   logic                     maskSel;
   logic                     grantValid;
   logic [CW-1:0]            grantIndex;
   logic                     grantFire;
   logic [31:0]              readValue;
   logic [N-1:0]             next_pending;
   logic [N-1:0]             next_eventDetected;
   logic [N-1:0]             next_doneStat;
   logic [N-1:0]             next_abortStat;
   logic [N-1:0]             clearDone;
   logic [N-1:0]             clearAbort;

   // ------------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------------

   // completion of the neighbour that this channel follows
   function automatic logic neighbourDone(input logic [N-1:0] done,
                                          input int idx,
                                          input logic dir);
      logic hit;
      hit = 1'b0;
      if (dir) begin
         if (idx + 1 < N) begin
            hit = done[idx + 1];
         end
      end else begin
         if (idx > 0) begin
            hit = done[idx - 1];
         end
      end
      return hit;
   endfunction

   // software view of one control word; unlisted bits stay zero
   function automatic logic [31:0] packCtrl(input dma_channel_pkg::ctrl_t c,
                                            input logic busyBit,
                                            input logic evt);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[dma_channel_pkg::BIT_BUSY]        = busyBit;
      w[dma_channel_pkg::BIT_CHAIN_DIR]   = c.chainDirectionSelect;
      w[dma_channel_pkg::BIT_ON]          = c.channelOn;
      w[dma_channel_pkg::BIT_ALLOW_OFF]   = c.allowEventsWhileOff;
      w[dma_channel_pkg::BIT_CHAIN_ALLOW] = c.chainAllow;
      w[dma_channel_pkg::BIT_AUTO]        = c.autoReenable;
      w[dma_channel_pkg::BIT_EVENT]       = evt;
      w[dma_channel_pkg::PRIO_LSB +: dma_channel_pkg::PRIO_W] =
         c.priorityLevel;
      return w;
   endfunction

   // writable fields of a control word; busy and event bits are ignored
   function automatic dma_channel_pkg::ctrl_t unpackCtrl(input logic [31:0] w);
      dma_channel_pkg::ctrl_t c;
      c.chainDirectionSelect = w[dma_channel_pkg::BIT_CHAIN_DIR];
      c.channelOn            = w[dma_channel_pkg::BIT_ON];
      c.allowEventsWhileOff  = w[dma_channel_pkg::BIT_ALLOW_OFF];
      c.chainAllow           = w[dma_channel_pkg::BIT_CHAIN_ALLOW];
      c.autoReenable         = w[dma_channel_pkg::BIT_AUTO];
      c.priorityLevel        =
         w[dma_channel_pkg::PRIO_LSB +: dma_channel_pkg::PRIO_W];
      return c;
   endfunction

   // ------------------------------------------------------------------
   // register port decode
   // ------------------------------------------------------------------
   assign req.write  = busWrite;
   assign req.read   = busRead;
   assign req.addr   = busAddr;
   assign req.data   = busWdata;
   assign statusSel  = (req.addr == dma_channel_pkg::IRQ_STATUS);
   assign maskSel    = (req.addr == dma_channel_pkg::IRQ_MASK);
   assign statusWord = (32'(abortStat) << dma_channel_pkg::ABORT_LSB)
                     | 32'(doneStat);
   assign clearDone  = (req.write && statusSel) ? busWdata[N-1:0] : '0;
   assign clearAbort = (req.write && statusSel)
                     ? busWdata[dma_channel_pkg::ABORT_LSB +: N] : '0;

   // ------------------------------------------------------------------
   // per-channel combinational terms
   // ------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gCh
         assign ctrlSel[g]  = (req.addr == 8'(dma_channel_pkg::CTRL_BASE
                             + dma_channel_pkg::CTRL_STRIDE * g));
         // events count while on, or while off if software allows it
         assign accept[g]   = ctrl[g].channelOn
                            | ctrl[g].allowEventsWhileOff;
         assign startOk[g]  = startEvent[g] & accept[g];
         assign abortOk[g]  = abortEvent[g] & accept[g];
         assign blockEnd[g] = active & moveDone & moveBlockEnd
                            & (activeCh == CW'(g));
         // a pending event waits until the channel is on
         assign request[g]  = pending[g] & ctrl[g].channelOn;
         // busy also covers the transaction that outlives a switch-off
         assign busy[g]     = ctrl[g].channelOn
                            | (active & (activeCh == CW'(g)));
         // direction is only looked at behind the chain-allow gate
         assign chainHit[g] = ctrl[g].chainAllow
                            & neighbourDone(blockEnd, g,
                                 ctrl[g].chainDirectionSelect);
         assign granted[g]  = grantFire & (grantIndex == CW'(g));
         assign prioFlat[2*g +: 2] = ctrl[g].priorityLevel;
         assign ctrlWord[g] = packCtrl(ctrl[g], busy[g],
                                       eventDetected[g]);
      end
   endgenerate

   // ------------------------------------------------------------------
   // arbitration
   // ------------------------------------------------------------------
   dma_priority_arbiter #(
      .N          (N),
      .CW         (CW)
   ) uArb (
      .request    (request),
      .prioFlat   (prioFlat),
      .grantValid (grantValid),
      .grantIndex (grantIndex)
   );

   // one transaction at a time; the next grant waits for moveDone
   assign grantFire = ce & ~active & grantValid;

   // ------------------------------------------------------------------
   // sticky next values: a set in the clearing cycle wins
   // ------------------------------------------------------------------
   assign next_pending       = (pending & ~granted & ~abortOk) | startOk;
   assign next_eventDetected = (eventDetected & ~granted)
                             | startOk | abortOk;
   assign next_doneStat      = (doneStat & ~clearDone) | blockEnd;
   assign next_abortStat     = (abortStat & ~clearAbort) | abortOk;

   // ------------------------------------------------------------------
   // read mux: unmapped addresses read zero
   // ------------------------------------------------------------------
   always_comb begin
      readValue = dma_channel_pkg::READ_IDLE;
      if (statusSel) begin
         readValue = statusWord;
      end else if (maskSel) begin
         readValue = irqMask;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (ctrlSel[i]) begin
               readValue = ctrlWord[i];
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // control registers: block end, then software, then chaining
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      for (int i = 0; i < N; i++) begin
         if (rst) begin
            ctrl[i] <= dma_channel_pkg::CTRL_RESET;
         end else if (ce) begin
            if (blockEnd[i] && !ctrl[i].autoReenable) begin
               ctrl[i].channelOn <= 1'b0;
            end
            if (req.write && ctrlSel[i]) begin
               ctrl[i] <= unpackCtrl(req.data);
            end
            if (chainHit[i]) begin
               ctrl[i].channelOn <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // event and interrupt flags
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         pending       <= '0;
         eventDetected <= '0;
         doneStat      <= '0;
         abortStat     <= '0;
         irqMask       <= dma_channel_pkg::MASK_RESET;
      end else if (ce) begin
         pending       <= next_pending;
         eventDetected <= next_eventDetected;
         doneStat      <= next_doneStat;
         abortStat     <= next_abortStat;
         if (req.write && maskSel) begin
            irqMask <= req.data;
         end
      end
   end

   // ------------------------------------------------------------------
   // transaction tracking towards the data mover
   // ------------------------------------------------------------------
   // switching a channel off never cuts a running move short
   always_ff @(posedge clk) begin
      if (rst) begin
         active      <= 1'b0;
         activeCh    <= '0;
         moveStart   <= 1'b0;
         moveChannel <= '0;
      end else if (ce) begin
         moveStart <= grantFire;
         if (grantFire) begin
            active      <= 1'b1;
            activeCh    <= grantIndex;
            moveChannel <= grantIndex;
         end else if (active && moveDone) begin
            active <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // read data, valid only in the cycle after the strobe
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         busRdata <= dma_channel_pkg::READ_IDLE;
      end else if (ce) begin
         busRdata <= req.read ? readValue : dma_channel_pkg::READ_IDLE;
      end
   end

   // level interrupt straight from the sticky bits and the mask
   assign irq = |(statusWord & irqMask);

endmodule

// [rtl/dma_priority_arbiter.sv]
// priority arbiter: highest level wins, lower channel number breaks ties
`timescale 1ns/1ps
module dma_priority_arbiter #(
   parameter int N  = 4,
   parameter int CW = 2
) (
   // requests and their levels, two bits per channel
   input  wire logic [N-1:0]   request,
   input  wire logic [2*N-1:0] prioFlat,
   // winner
   output logic                grantValid,
   output logic [CW-1:0]       grantIndex
);

   // ------------------------------------------------------------------
   // scan from the top channel down; >= lets the lower number take ties
   // ------------------------------------------------------------------
   always_comb begin
      logic [1:0] bestPrio;
      bestPrio   = 2'h0;
      grantValid = 1'b0;
      grantIndex = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (request[i] && (!grantValid || prioFlat[2*i +: 2] >= bestPrio)) begin
            grantValid = 1'b1;
            grantIndex = CW'(i);
            bestPrio   = prioFlat[2*i +: 2];
         end
      end
   end

endmodule

// [shared/dma_channel_pkg.sv]
// constants, field layout and carrier types of the dma channel control block
package dma_channel_pkg;

   // ------------------------------------------------------------------
   // register map (byte addresses on the plain register port)
   // ------------------------------------------------------------------
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  CTRL_BASE     = 8'h00; // channel n at base + 4*n
   localparam logic [7:0]  CTRL_STRIDE   = 8'h04;
   localparam logic [7:0]  IRQ_STATUS    = 8'h40;
   localparam logic [7:0]  IRQ_MASK      = 8'h44;

   // ------------------------------------------------------------------
   // control word field positions
   // ------------------------------------------------------------------
   localparam int BIT_BUSY        = 15;
   localparam int BIT_CHAIN_DIR   = 8;
   localparam int BIT_ON          = 7;
   localparam int BIT_ALLOW_OFF   = 6;
   localparam int BIT_CHAIN_ALLOW = 5;
   localparam int BIT_AUTO        = 4;
   localparam int BIT_EVENT       = 2;
   localparam int PRIO_LSB        = 0;
   localparam int PRIO_W          = 2;

   // status word: block-complete bits low, abort bits from here up
   localparam int ABORT_LSB       = 16;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
   localparam logic [31:0] READ_IDLE     = 32'h0000_0000;

   // ------------------------------------------------------------------
   // carrier types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic              chainDirectionSelect;
      logic              channelOn;
      logic              allowEventsWhileOff;
      logic              chainAllow;
      logic              autoReenable;
      logic [PRIO_W-1:0] priorityLevel;
   } ctrl_t;

   typedef struct packed {
      logic              write;
      logic              read;
      logic [ADDR_W-1:0] addr;
      logic [31:0]       data;
   } bus_req_t;

   localparam ctrl_t CTRL_RESET = '0;

endpackage

// [test/dma_channel_control_chk.sv]
// port assertions for the dma channel control block
`timescale 1ns/1ps
module dma_channel_control_chk #(
   parameter int N  = 4,
   parameter int CW = 2
) (
   // clock, reset, enable
   input wire logic          clk,
   input wire logic          rst,
   input wire logic          ce,
   // register port
   input wire logic [7:0]    busAddr,
   input wire logic [31:0]   busWdata,
   input wire logic          busWrite,
   input wire logic          busRead,
   input wire logic [31:0]   busRdata,
   // events and mover
   input wire logic [N-1:0]  startEvent,
   input wire logic [N-1:0]  abortEvent,
   input wire logic          moveStart,
   input wire logic [CW-1:0] moveChannel,
   input wire logic          moveDone,
   input wire logic          moveBlockEnd,
   // interrupt
   input wire logic          irq
);
   // --------------------
   // helper state
   // --------------------
   logic act;
   // a transaction runs from its start pulse to its done
   always_ff @(posedge clk) begin
      if (rst)
         act <= 1'b0;
      else if (ce)
         act <= moveStart | (act & ~moveDone);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // --------------------
   // properties
   // --------------------
   sequence s_ctrlRead;
      $past(busRead) && $past(busAddr) < 8'h40;
   endsequence
   sequence s_doneSeen;
      moveDone && act;
   endsequence
   property p_rdIdle;
      !$past(busRead) && $past(ce) |-> busRdata == 32'h0;
   endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
   property p_resv;
      s_ctrlRead |-> busRdata[31:16] == 16'h0 && busRdata[14:9] == 6'h0
         && !busRdata[3];
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bit set");
   property p_busyOn;
      s_ctrlRead ##0 busRdata[7] |-> busRdata[15];
   endproperty
   a_busyOn: assert property (p_busyOn) else $error("on but not busy");
   property p_pulse;
      moveStart && ce |=> !moveStart;
   endproperty
   a_pulse: assert property (p_pulse) else $error("start too long");
   property p_single;
      moveStart |-> !act;
   endproperty
   a_single: assert property (p_single) else $error("start while busy");
   property p_gap;
      s_doneSeen |=> !moveStart;
   endproperty
   a_gap: assert property (p_gap) else $error("start right after done");
   property p_held;
      !moveStart && !$past(rst) |-> $stable(moveChannel);
   endproperty
   a_held: assert property (p_held) else $error("channel moved");
   property p_irqRise;
      $rose(irq) |-> $past(moveDone || |abortEvent || busWrite);
   endproperty
   a_irqRise: assert property (p_irqRise) else $error("irq without cause");
   property p_irqFall;
      $fell(irq) && !$past(rst) |-> $past(busWrite);
   endproperty
   a_irqFall: assert property (p_irqFall) else $error("irq fell alone");
endmodule

// [test/dma_mover_model.sv]
// behavioural data mover that answers the channel block
`timescale 1ns/1ps
module dma_mover_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // bench controls: latency and block end
   input  wire logic [3:0] delay,
   input  wire logic       lastOfBlock,
   // mover handshake
   input  wire logic       moveStart,
   output logic            moveDone,
   output logic            moveBlockEnd
);
   logic [3:0] left;
   logic       run;
   logic       junk;
   // one transaction per start, done delay plus one cycles after the start is taken
   always_ff @(posedge clk) begin
      if (rst) begin
         run      <= 1'b0;
         left     <= 4'h0;
         moveDone <= 1'b0;
         junk     <= 1'b0;
      end else begin
         junk     <= ~junk;
         moveDone <= run && left == 4'h0;
         if (moveStart) begin
            run  <= 1'b1;
            left <= delay;
         end else if (run && left == 4'h0)
            run <= 1'b0;
         else if (run)
            left <= left - 4'h1;
      end
   end
   // qualifier means nothing outside done, so it never holds still there
   assign moveBlockEnd = moveDone ? lastOfBlock : junk;
endmodule

// [test/tb.sv]
// self-checking bench for the dma channel control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("Error %s expected %0h seen %0h", nm, e, g); \
   end \
end
module tb;
   // --------------------
   // signals
   // --------------------
   logic        clk;
   logic        rst;
   logic        ce;
   logic [7:0]  busAddr;
   logic [31:0] busWdata;
   logic        busWrite;
   logic        busRead;
   logic [31:0] busRdata;
   logic [3:0]  startEvent;
   logic [3:0]  abortEvent;
   logic        moveStart;
   logic [1:0]  moveChannel;
   logic        moveDone;
   logic        moveBlockEnd;
   logic        irq;
   logic [3:0]  moveDelay;
   logic        lastOfBlock;
   logic        irqSeen;
   int          errors;
   int          check_count;
   // clock enable driven by the bench so that freezing can be exercised
   dma_channel_control #(.N(4)) uut (.clk(clk), .rst(rst), .ce(ce),
      .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite),
      .busRead(busRead), .busRdata(busRdata), .startEvent(startEvent),
      .abortEvent(abortEvent), .moveStart(moveStart),
      .moveChannel(moveChannel), .moveDone(moveDone),
      .moveBlockEnd(moveBlockEnd), .irq(irq));
   dma_mover_model mover (.clk(clk), .rst(rst), .delay(moveDelay),
      .lastOfBlock(lastOfBlock), .moveStart(moveStart),
      .moveDone(moveDone), .moveBlockEnd(moveBlockEnd));
   // --------------------
   // bus and event tasks
   // --------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      busAddr <= a;
      busWdata <= d;
      busWrite <= 1'b1;
      @(posedge clk);
      busWrite <= 1'b0;
      @(posedge clk);
   endtask
   // read and compare; irq is sampled in the answer cycle too
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      busAddr <= a;
      busRead <= 1'b1;
      @(posedge clk);
      busRead <= 1'b0;
      #1;
      irqSeen = irq;
      `CHK($sformatf("reg %0h", a), e, busRdata)
      @(posedge clk);
   endtask
   // pulse lowers without a trailing edge, so never call it twice in a row
   task automatic ev(input logic [3:0] s, input logic [3:0] b);
      startEvent <= s;
      abortEvent <= b;
      @(posedge clk);
      startEvent <= 4'h0;
      abortEvent <= 4'h0;
   endtask
   // looks first at the cycle it is called in: a grant may already have
   // been launched by the edge that ended the previous task
   task automatic wait_for(input bit forDone);
      bit seen;
      #1;
      seen = forDone ? moveDone : moveStart;
      for (int i = 0; i < 50 && !seen; i++) begin
         @(posedge clk);
         #1;
         seen = forDone ? moveDone : moveStart;
      end
      `CHK("handshake", 1'b1, seen)
      @(posedge clk);
   endtask
   // --------------------
   // scenarios
   // --------------------
   task automatic t_regs();
      for (int i = 0; i < 4; i++)
         rc(8'(4 * i), 32'h0);
      rc(8'h40, 32'h0);
      rc(8'h80, 32'h0);
      wr(8'h04, 32'hFFFF_FFFF);
      rc(8'h04, 32'h0000_81F3);
      for (int p = 0; p < 4; p++) begin
         wr(8'h04, 32'(p));
         rc(8'h04, 32'(p));
      end
      // a write offered while the enable is low must leave no trace
      ce <= 1'b0;
      wr(8'h00, 32'h80);
      ce <= 1'b1;
      rc(8'h00, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_move();
      moveDelay <= 4'hA;
      lastOfBlock <= 1'b1;
      wr(8'h44, 32'h1);
      wr(8'h00, 32'h80);
      ev(4'h1, 4'h0);
      wait_for(1'b0);
      `CHK("moveChannel", 2'h0, moveChannel)
      ev(4'h1, 4'h0);
      rc(8'h00, 32'h0000_8084);
      wait_for(1'b1);
      rc(8'h00, 32'h0000_0004);
      `CHK("irq", 1'b1, irqSeen)
      wr(8'h40, 32'h1);
      rc(8'h40, 32'h0);
      `CHK("irq", 1'b0, irqSeen)
      $display("test move done");
   endtask
   task automatic t_suspend();
      lastOfBlock <= 1'b0;
      wr(8'h00, 32'h90);
      wait_for(1'b0);
      wr(8'h00, 32'h10);
      rc(8'h00, 32'h0000_8010);
      wait_for(1'b1);
      rc(8'h00, 32'h0000_0010);
      wr(8'h00, 32'h90);
      lastOfBlock <= 1'b1;
      ev(4'h1, 4'h0);
      wait_for(1'b0);
      wait_for(1'b1);
      rc(8'h00, 32'h0000_8090);
      wr(8'h00, 32'h0);
      wr(8'h40, 32'h1);
      $display("test suspend done");
   endtask
   task automatic t_events();
      bit seen;
      seen = 0;
      moveDelay <= 4'h2;
      lastOfBlock <= 1'b0;
      ev(4'h4, 4'h0);
      rc(8'h08, 32'h0);
      wr(8'h08, 32'h80);
      repeat (6) begin
         @(posedge clk);
         #1;
         seen |= moveStart;
      end
      @(posedge clk);
      `CHK("moveStart", 1'b0, seen)
      wr(8'h08, 32'h40);
      ev(4'h4, 4'h0);
      rc(8'h08, 32'h0000_0044);
      wr(8'h08, 32'hC0);
      wait_for(1'b0);
      `CHK("moveChannel", 2'h2, moveChannel)
      wait_for(1'b1);
      wr(8'h08, 32'h40);
      ev(4'h0, 4'h4);
      rc(8'h40, 32'h0004_0000);
      `CHK("irq", 1'b0, irqSeen)
      wr(8'h44, 32'h0004_0000);
      rc(8'h40, 32'h0004_0000);
      `CHK("irq", 1'b1, irqSeen)
      wr(8'h40, 32'h0004_0000);
      rc(8'h40, 32'h0);
      `CHK("irq", 1'b0, irqSeen)
      $display("test events done");
   endtask
   task automatic t_chain();
      logic [31:0] c1 [2] = '{32'h100, 32'h120};
      logic [31:0] c3 [2] = '{32'h120, 32'h020};
      lastOfBlock <= 1'b1;
      wr(8'h08, 32'h90);
      for (int i = 0; i < 2; i++) begin
         wr(8'h04, c1[i]);
         wr(8'h0C, c3[i]);
         ev(4'h4, 4'h0);
         wait_for(1'b0);
         wait_for(1'b1);
         rc(8'h04, c1[i] | (i != 0 ? 32'h8080 : 32'h0));
         rc(8'h0C, c3[i] | (i != 0 ? 32'h8080 : 32'h0));
      end
      wr(8'h04, 32'h0);
      wr(8'h0C, 32'h0);
      wr(8'h40, 32'hF);
      $display("test chain done");
   endtask
   task automatic t_arb();
      logic [1:0] order [3] = '{2'h1, 2'h3, 2'h0};
      moveDelay <= 4'hA;
      lastOfBlock <= 1'b0;
      wr(8'h00, 32'h91);
      wr(8'h04, 32'h93);
      wr(8'h0C, 32'h93);
      ev(4'h4, 4'h0);
      wait_for(1'b0);
      ev(4'hB, 4'h0);
      foreach (order[k]) begin
         wait_for(1'b0);
         `CHK("moveChannel", order[k], moveChannel)
      end
      wait_for(1'b1);
      $display("test arbitration done");
   endtask
   // --------------------
   // run control
   // --------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      busAddr = 8'h00;
      busWdata = 32'h0;
      busWrite = 1'b0;
      busRead = 1'b0;
      startEvent = 4'h0;
      abortEvent = 4'h0;
      moveDelay = 4'h2;
      lastOfBlock = 1'b0;
      errors = 0;
      check_count = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_move();
      t_suspend();
      t_events();
      t_chain();
      t_arb();
      end_of_test();
   end
endmodule
bind dma_channel_control dma_channel_control_chk #(.N(N), .CW(CW)) chk (
   .clk(clk), .rst(rst), .ce(ce), .busAddr(busAddr), .busWdata(busWdata),
   .busWrite(busWrite), .busRead(busRead), .busRdata(busRdata),
   .startEvent(startEvent), .abortEvent(abortEvent),
   .moveStart(moveStart), .moveChannel(moveChannel),
   .moveDone(moveDone), .moveBlockEnd(moveBlockEnd), .irq(irq));
